// file: srv_pkg.sv
// Package: register map, field layout and types of the sector read and verify command block
`default_nettype none
package srv_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_FEATURES  = 8'h04;
  localparam logic [7:0] OFF_ERROR     = 8'h04;
  localparam logic [7:0] OFF_COUNT     = 8'h08;
  localparam logic [7:0] OFF_ADDR_LOW  = 8'h0C;
  localparam logic [7:0] OFF_ADDR_MID  = 8'h10;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h14;
  localparam logic [7:0] OFF_UNIT      = 8'h18;
  localparam logic [7:0] OFF_OPCODE    = 8'h1C;
  localparam logic [7:0] OFF_STATE     = 8'h1C;
  localparam logic [7:0] OFF_CONTROL   = 8'h20;
  localparam logic [7:0] OFF_MEDIA     = 8'h24;
  localparam logic [7:0] OFF_XFER      = 8'h28;
  // Command codes
  localparam logic [7:0] CMD_READ_EXT  = 8'h24;
  localparam logic [7:0] CMD_VERIFY    = 8'h40;
  // Field positions
  localparam int BIT_HOB       = 7;
  localparam int BIT_LBA_MODE  = 6;
  localparam int BIT_DEV       = 4;
  localparam int BIT_UNC       = 6;
  localparam int BIT_MC        = 5;
  localparam int BIT_ID_NOT_FOUND_FLAG      = 4;
  localparam int BIT_MCR       = 3;
  localparam int BIT_ABORTED_FLAG      = 2;
  localparam int BIT_NM        = 1;
  localparam int BIT_BSY       = 7;
  localparam int BIT_DEVICE_READY_FLAG      = 6;
  localparam int BIT_DF        = 5;
  localparam int BIT_DRQ       = 3;
  localparam int BIT_ERR       = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_STATE = 8'h40;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Media-side sector report
  typedef struct packed {
    logic       done;
    logic       uncorrectable;
    logic       not_found;
    logic       out_of_range;
    logic       fault;
    logic       udma_error;
  } srv_media_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_DONE  = 4'b1000
  } srv_state_type;
endpackage
`default_nettype wire

// file: srv_top.sv
// Device-side task-file command block with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module srv_top #(
  parameter bit PACKET_SET = 1'b0,
  parameter bit REMOVABLE  = 1'b1
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Media engine: sector requests and per-sector reports
  output logic                       sector_req,
  output logic [47:0]                sector_addr,
  input  wire srv_pkg::srv_media_type media_rpt,
  // Removable media sense, from pins
  input  wire logic                  media_present_pin,
  input  wire logic                  media_change_pin,
  input  wire logic                  change_request_pin
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       chg_prev_q;
  logic       req_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      chg_prev_q <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {change_request_pin, media_change_pin, media_present_pin};
      pin_sync_q <= pin_meta_q;
      chg_prev_q <= pin_sync_q[1];
      req_prev_q <= pin_sync_q[2];
    end
  end

  wire logic chg_event = pin_sync_q[1] & ~chg_prev_q;
  wire logic req_event = pin_sync_q[2] & ~req_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] waddr_q;
  logic [7:0] wbyte_q;
  logic       wen_q;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take  = s_axi_wvalid & s_axi_wready;
  wire logic wr_fire = (aw_held_q | aw_take) & (w_held_q | w_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      waddr_q      <= 8'h00;
      wbyte_q      <= 8'h00;
      wen_q        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= srv_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        waddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        wen_q   <= s_axi_wstrb[0];
      end
      aw_held_q <= (aw_held_q | aw_take) & ~wr_fire;
      w_held_q  <= (w_held_q | w_take) & ~wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known(aw_take ? s_axi_awaddr : waddr_q)
                        ? srv_pkg::RESP_OKAY : srv_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_known(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == srv_pkg::OFF_FEATURES || a == srv_pkg::OFF_COUNT) begin
      ok = 1'b1;
    end else if (a == srv_pkg::OFF_ADDR_LOW || a == srv_pkg::OFF_ADDR_MID) begin
      ok = 1'b1;
    end else if (a == srv_pkg::OFF_ADDR_HIGH || a == srv_pkg::OFF_UNIT) begin
      ok = 1'b1;
    end else if (a == srv_pkg::OFF_OPCODE || a == srv_pkg::OFF_CONTROL) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Write is committed one cycle after both halves are taken
  logic       wr_go_q;
  logic [7:0] wr_addr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_go_q   <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_go_q   <= wr_fire;
      wr_addr_q <= aw_take ? s_axi_awaddr : waddr_q;
    end
  end
  wire logic [7:0] wr_data = wbyte_q;
  wire logic       wr_ok   = wr_go_q & wen_q;

  //////////////////////////////////////////////////////////////////////////////
  // Task-file registers; count and address registers each keep current and previous value
  logic [7:0]  count_q, count_prev_q;
  logic [7:0]  low_q, low_prev_q;
  logic [7:0]  mid_q, mid_prev_q;
  logic [7:0]  high_q, high_prev_q;
  logic [7:0]  feat_q;
  logic [7:0]  unit_q;
  logic        hob_q;
  logic [7:0]  err_q;
  logic [7:0]  stat_q;
  logic        busy_now;
  logic        cmd_start;
  logic        ext_q;
  logic        fail_load;
  logic [47:0] fail_addr;
  logic        rd_xfer;

  assign busy_now  = stat_q[srv_pkg::BIT_BSY];
  assign cmd_start = wr_ok & (wr_addr_q == srv_pkg::OFF_OPCODE) & ~busy_now;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {count_q, count_prev_q} <= {srv_pkg::RST_BYTE, srv_pkg::RST_BYTE};
      {low_q, low_prev_q}     <= {srv_pkg::RST_BYTE, srv_pkg::RST_BYTE};
      {mid_q, mid_prev_q}     <= {srv_pkg::RST_BYTE, srv_pkg::RST_BYTE};
      {high_q, high_prev_q}   <= {srv_pkg::RST_BYTE, srv_pkg::RST_BYTE};
      feat_q <= srv_pkg::RST_BYTE;
      unit_q <= srv_pkg::RST_BYTE;
      hob_q  <= 1'b0;
    end else if (fail_load) begin
      // Failing address replaces the address registers
      low_q       <= fail_addr[7:0];
      mid_q       <= fail_addr[15:8];
      high_q      <= fail_addr[23:16];
      low_prev_q  <= fail_addr[31:24];
      mid_prev_q  <= fail_addr[39:32];
      high_prev_q <= fail_addr[47:40];
      if (!ext_q) begin
        unit_q[3:0] <= fail_addr[27:24];
      end
    end else if (wr_ok && !busy_now) begin
      // Writes while busy are ignored
      if (wr_addr_q == srv_pkg::OFF_COUNT) begin
        {count_prev_q, count_q} <= {count_q, wr_data};
      end else if (wr_addr_q == srv_pkg::OFF_ADDR_LOW) begin
        {low_prev_q, low_q} <= {low_q, wr_data};
      end else if (wr_addr_q == srv_pkg::OFF_ADDR_MID) begin
        {mid_prev_q, mid_q} <= {mid_q, wr_data};
      end else if (wr_addr_q == srv_pkg::OFF_ADDR_HIGH) begin
        {high_prev_q, high_q} <= {high_q, wr_data};
      end else if (wr_addr_q == srv_pkg::OFF_FEATURES) begin
        feat_q <= wr_data;
      end else if (wr_addr_q == srv_pkg::OFF_UNIT) begin
        unit_q <= wr_data;
      end else if (wr_addr_q == srv_pkg::OFF_CONTROL) begin
        hob_q <= wr_data[srv_pkg::BIT_HOB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  srv_pkg::srv_state_type state_q;
  logic [16:0] remain_q;
  logic [47:0] cur_addr_q;
  logic        media_chg_q;
  logic        mcr_q;
  logic        drq_q;

  assign fail_addr = cur_addr_q;
  assign fail_load = (state_q == srv_pkg::ST_RUN) & media_rpt.done
                     & (media_rpt.uncorrectable | media_rpt.not_found
                        | media_rpt.out_of_range | media_rpt.fault
                        | media_rpt.udma_error);

  wire logic known_cmd = (wr_data == srv_pkg::CMD_READ_EXT) | (wr_data == srv_pkg::CMD_VERIFY);
  wire logic refuse    = PACKET_SET | ~known_cmd;
  wire logic no_media  = REMOVABLE & ~pin_sync_q[0];
  wire logic is_ext    = wr_data == srv_pkg::CMD_READ_EXT;
  wire logic [16:0] ext_count = ({count_prev_q, count_q} == 16'h0000)
                                ? 17'h10000 : {1'b0, count_prev_q, count_q};
  wire logic [16:0] vfy_count = (count_q == 8'h00) ? 17'h00100 : {9'h000, count_q};

  assign sector_req  = (state_q == srv_pkg::ST_RUN);
  assign sector_addr = cur_addr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= srv_pkg::ST_IDLE;
      ext_q      <= 1'b0;
      remain_q   <= 17'h00000;
      cur_addr_q <= 48'h000000000000;
      err_q      <= srv_pkg::RST_BYTE;
      stat_q     <= srv_pkg::RST_STATE;
      drq_q      <= 1'b0;
    end else begin
      case (state_q)
        srv_pkg::ST_IDLE: begin
          if (cmd_start) begin
            ext_q <= is_ext;
            remain_q <= is_ext ? ext_count : vfy_count;
            cur_addr_q <= is_ext
                ? {high_prev_q, mid_prev_q, low_prev_q, high_q, mid_q, low_q}
                : {20'h00000, unit_q[3:0], high_q, mid_q, low_q};
            err_q <= 8'h00;
            if (refuse || no_media || media_chg_q || mcr_q) begin
              err_q[srv_pkg::BIT_ABORTED_FLAG] <= refuse;
              err_q[srv_pkg::BIT_NM]   <= no_media & ~refuse;
              err_q[srv_pkg::BIT_MC]   <= media_chg_q & ~refuse;
              err_q[srv_pkg::BIT_MCR]  <= mcr_q & ~refuse;
              stat_q <= 8'h41;
              state_q <= srv_pkg::ST_IDLE;
            end else begin
              stat_q <= 8'hC0;
              state_q <= srv_pkg::ST_RUN;
            end
          end
        end
        srv_pkg::ST_RUN: begin
          if (fail_load) begin
            err_q[srv_pkg::BIT_UNC]  <= media_rpt.uncorrectable;
            err_q[srv_pkg::BIT_ID_NOT_FOUND_FLAG] <= media_rpt.not_found | media_rpt.out_of_range;
            err_q[srv_pkg::BIT_ABORTED_FLAG] <= media_rpt.udma_error | media_rpt.fault
                                        | (media_rpt.out_of_range & ~media_rpt.not_found
                                           & media_rpt.udma_error);
            stat_q <= {1'b0, 1'b1, media_rpt.fault, 4'h0, 1'b1};
            if (ext_q) begin
              // Data of the failing sector is still offered once
              stat_q[srv_pkg::BIT_DRQ] <= 1'b1;
              drq_q <= 1'b1;
              stat_q[srv_pkg::BIT_BSY] <= 1'b0;
            end
            state_q <= srv_pkg::ST_IDLE;
          end else if (media_rpt.done) begin
            remain_q   <= remain_q - 17'h00001;
            cur_addr_q <= cur_addr_q + 48'h000000000001;
            if (ext_q) begin
              stat_q <= 8'h48;
              drq_q  <= 1'b1;
              state_q <= srv_pkg::ST_XFER;
            end else if (remain_q == 17'h00001) begin
              state_q <= srv_pkg::ST_DONE;
            end
          end
        end
        srv_pkg::ST_XFER: begin
          // Host drains the sector by reading the transfer register
          if (!drq_q) begin
            stat_q  <= 8'hC0;
            state_q <= (remain_q == 17'h00000) ? srv_pkg::ST_DONE : srv_pkg::ST_RUN;
          end
        end
        srv_pkg::ST_DONE: begin
          stat_q  <= srv_pkg::RST_STATE;
          state_q <= srv_pkg::ST_IDLE;
        end
        default: state_q <= srv_pkg::ST_IDLE;
      endcase
      if (rd_xfer) begin
        drq_q <= 1'b0;
        stat_q[srv_pkg::BIT_DRQ] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Media change tracking: event sets win over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      media_chg_q <= 1'b0;
      mcr_q       <= 1'b0;
    end else begin
      media_chg_q <= REMOVABLE & (chg_event | (media_chg_q & ~cmd_start));
      mcr_q <= REMOVABLE & (req_event | (mcr_q & ~(cmd_start & ~refuse)));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_xfer = s_axi_arvalid & s_axi_arready & (s_axi_araddr == srv_pkg::OFF_XFER) & drq_q;

  function automatic logic [7:0] pick(input logic h, input logic [7:0] cur,
                                      input logic [7:0] prev);
    return h ? prev : cur;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= srv_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= srv_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == srv_pkg::OFF_ERROR) begin
        s_axi_rdata[7:0] <= err_q;
      end else if (s_axi_araddr == srv_pkg::OFF_COUNT) begin
        s_axi_rdata[7:0] <= pick(hob_q, count_q, count_prev_q);
      end else if (s_axi_araddr == srv_pkg::OFF_ADDR_LOW) begin
        s_axi_rdata[7:0] <= pick(hob_q, low_q, low_prev_q);
      end else if (s_axi_araddr == srv_pkg::OFF_ADDR_MID) begin
        s_axi_rdata[7:0] <= pick(hob_q, mid_q, mid_prev_q);
      end else if (s_axi_araddr == srv_pkg::OFF_ADDR_HIGH) begin
        s_axi_rdata[7:0] <= pick(hob_q, high_q, high_prev_q);
      end else if (s_axi_araddr == srv_pkg::OFF_UNIT) begin
        s_axi_rdata[7:0] <= unit_q;
      end else if (s_axi_araddr == srv_pkg::OFF_STATE) begin
        s_axi_rdata[7:0] <= stat_q;
      end else if (s_axi_araddr == srv_pkg::OFF_CONTROL) begin
        s_axi_rdata[7:0] <= {hob_q, 7'h00};
      end else if (s_axi_araddr == srv_pkg::OFF_MEDIA) begin
        s_axi_rdata[7:0] <= {5'h00, mcr_q, media_chg_q, pin_sync_q[0]};
      end else if (s_axi_araddr == srv_pkg::OFF_XFER) begin
        s_axi_rdata <= {16'h0000, cur_addr_q[15:0]};
      end else begin
        s_axi_rresp <= srv_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: srv_sva.sv
// Checker: bus handshake and command-end assertions on the srv_top ports
`timescale 1ns/100ps
`default_nettype none
module srv_sva (
  // Clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // Register bus
  input wire logic [7:0]             s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [7:0]             s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  // Media side
  input wire logic                   sector_req,
  input wire logic [47:0]            sector_addr,
  input wire srv_pkg::srv_media_type media_rpt,
  input wire logic                   media_present_pin,
  input wire logic                   media_change_pin,
  input wire logic                   change_request_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write answer late");
  a_ar_gate:
    assert property (s_axi_arready == !s_axi_rvalid) else $error("read address gate wrong");
  a_unmapped_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
      |=> s_axi_rresp == srv_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_byte_lanes:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rdata[31:16] == 16'h0
      && (s_axi_rdata[15:8] == 8'h0 || $past(s_axi_araddr) == srv_pkg::OFF_XFER))
    else $error("upper lanes set");
  a_ready_idle:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == srv_pkg::OFF_STATE
      |=> s_axi_rdata[srv_pkg::BIT_BSY] || s_axi_rdata[srv_pkg::BIT_DEVICE_READY_FLAG])
    else $error("idle without ready");
  a_error_ends:
    assert property (sector_req && media_rpt.done && media_rpt.uncorrectable
      |-> ##[1:3] !sector_req) else $error("command not ended on error");
  a_reset_quiet:
    assert property ($rose(aresetn) |-> !sector_req && !s_axi_bvalid && !s_axi_rvalid)
    else $error("activity after reset");
endmodule
bind srv_top srv_sva u_srv_sva (.*);
`default_nettype wire

// file: srv_media_model.sv
// Media engine model: answers sector requests, failing one commanded address
`timescale 1ns/100ps
`default_nettype none
module srv_media_model (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Requests and commanded behaviour
  input  wire logic                   sector_req,
  input  wire logic [47:0]            sector_addr,
  input  wire logic [2:0]             lat,
  input  wire logic [47:0]            fail_addr,
  input  wire srv_pkg::srv_media_type fail_kind,
  // Sector reports
  output var srv_pkg::srv_media_type  media_rpt
);
  logic [2:0] cnt_q;
  // One-cycle report; count restarts so each sector is answered once
  always_ff @(posedge aclk) begin
    if (!aresetn || !sector_req || media_rpt.done) begin
      cnt_q     <= 3'h0;
      media_rpt <= '0;
    end else if (cnt_q == lat) begin
      media_rpt      <= (sector_addr == fail_addr) ? fail_kind : '0;
      media_rpt.done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: test_srv_top.sv
// Testbench: register-level command scenarios for srv_top
`timescale 1ns/100ps
`default_nettype none
module test_srv_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sreq, pres, chg, creq, drq_seen;
  logic [7:0]  awaddr, araddr, st, er;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr, br;
  logic [47:0] saddr, fail_addr;
  logic [2:0]  lat;
  int          error_cnt, check_count, sect_n, n0;
  srv_pkg::srv_media_type rpt, fail_kind;
  srv_pkg::srv_media_type kinds [5] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  logic [7:0]  exp_er [5] = '{8'h40, 8'h10, 8'h00, 8'h04, 8'h04};

  srv_top u_srv_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sector_req(sreq), .sector_addr(saddr), .media_rpt(rpt),
    .media_present_pin(pres), .media_change_pin(chg), .change_request_pin(creq));
  srv_media_model u_srv_media_model (.aclk(aclk), .aresetn(aresetn), .sector_req(sreq),
    .sector_addr(saddr), .lat(lat), .fail_addr(fail_addr), .fail_kind(fail_kind),
    .media_rpt(rpt));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (rpt.done === 1'b1) sect_n <= sect_n + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // No wait limit here: only the watchdog ends a stuck handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // Issues a command, drains any data, then leaves final state and error bytes
  task automatic run(input logic [7:0] cnt, input logic [27:0] a, input logic [7:0] op);
    n0 = sect_n;
    wr(srv_pkg::OFF_COUNT, {24'h0, cnt});
    wr(srv_pkg::OFF_ADDR_LOW, {24'h0, a[7:0]});
    wr(srv_pkg::OFF_ADDR_MID, {24'h0, a[15:8]});
    wr(srv_pkg::OFF_ADDR_HIGH, {24'h0, a[23:16]});
    wr(srv_pkg::OFF_UNIT, {24'h0, 4'h5, a[27:24]});
    wr(srv_pkg::OFF_OPCODE, {24'h0, op});
    drq_seen = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      rd(srv_pkg::OFF_STATE);
      if (rv[srv_pkg::BIT_DRQ]) begin
        drq_seen = 1'b1;
        rd(srv_pkg::OFF_XFER);
      end else if (!rv[srv_pkg::BIT_BSY]) break;
    end
    st = rv[7:0];
    rd(srv_pkg::OFF_ERROR);
    er = rv[7:0];
  endtask
  task automatic addr_chk(input logic [47:0] fa, input int h);
    for (int j = 0; j < 3; j++) begin
      rd(srv_pkg::OFF_ADDR_LOW + 8'(4 * j));
      chk(rv, {24'h0, fa[8 * (j + 3 * h) +: 8]});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, chg, creq} = '0;
    {awaddr, araddr, wdata, error_cnt, check_count} = '0;
    {pres, lat, fail_addr, fail_kind} = {1'b1, 3'h5, 48'hFFFF_FFFF_FFFF, 6'h00};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(srv_pkg::OFF_STATE);
    chk(rv, 32'h40);
    rd(8'h30);
    chk({30'h0, rr}, {30'h0, srv_pkg::RESP_SLVERR});
    wr(8'h30, 32'h0);
    chk({30'h0, br}, {30'h0, srv_pkg::RESP_SLVERR});
    $display("reset test done");
    run(8'h02, 28'h0000100, srv_pkg::CMD_VERIFY);
    chk({24'h0, st}, 32'h40);
    chk({31'h0, drq_seen}, 32'h0);
    chk(sect_n - n0, 2);
    rd(srv_pkg::OFF_UNIT);
    chk({31'h0, rv[srv_pkg::BIT_DEV]}, 32'h1);
    lat <= 3'h0;
    run(8'h00, 28'h0001000, srv_pkg::CMD_VERIFY);
    chk(sect_n - n0, 256);
    $display("verify test done");
    for (int k = 0; k < 5; k++) begin
      fail_kind <= kinds[k];
      fail_addr <= 48'h6000000;
      run(8'h04, 28'h5FFFFFE, srv_pkg::CMD_VERIFY);
      chk({28'h0, st[7:5], st[3]}, {29'h1, k == 3, 1'b0});
      chk({31'h0, st[0]}, {31'h0, |er});
      if (k == 2) chk({31'h0, er[4] ^ er[2]}, 32'h1);
      else chk({24'h0, er}, {24'h0, exp_er[k]});
      addr_chk(48'h6000000, 0);
      rd(srv_pkg::OFF_UNIT);
      chk({27'h0, rv[4:0]}, 32'h16);
    end
    $display("verify error test done");
    fail_kind <= kinds[0];
    fail_addr <= 48'h665544112234;
    wr(srv_pkg::OFF_COUNT, 32'h0);
    wr(srv_pkg::OFF_ADDR_LOW, 32'h44);
    wr(srv_pkg::OFF_ADDR_MID, 32'h55);
    wr(srv_pkg::OFF_ADDR_HIGH, 32'h66);
    run(8'h03, 28'h0112233, srv_pkg::CMD_READ_EXT);
    chk({31'h0, drq_seen}, 32'h1);
    chk({24'h0, st[7:0] & 8'hA9}, 32'h01);
    chk({24'h0, er}, 32'h40);
    for (int h = 0; h < 2; h++) begin
      wr(srv_pkg::OFF_CONTROL, {24'h0, h[0], 7'h0});
      addr_chk(48'h665544112234, h);
    end
    wr(srv_pkg::OFF_CONTROL, 32'h0);
    fail_addr <= 48'hFFFF_FFFF_FFFF;
    run(8'h01, 28'h0, 8'hEE);
    chk({31'h0, er[srv_pkg::BIT_ABORTED_FLAG]}, 32'h1);
    $display("extended read test done");
    pres <= 1'b0;
    repeat (4) @(posedge aclk);
    run(8'h01, 28'h0, srv_pkg::CMD_VERIFY);
    chk({31'h0, er[srv_pkg::BIT_NM]}, 32'h1);
    chk(sect_n - n0, 0);
    pres <= 1'b1;
    chg  <= 1'b1;
    repeat (4) @(posedge aclk);
    run(8'h01, 28'h0, srv_pkg::CMD_VERIFY);
    chk({31'h0, er[srv_pkg::BIT_MC]}, 32'h1);
    run(8'h01, 28'h0, srv_pkg::CMD_VERIFY);
    chk({31'h0, er[srv_pkg::BIT_MC]}, 32'h0);
    creq <= 1'b1;
    repeat (4) @(posedge aclk);
    run(8'h01, 28'h0, srv_pkg::CMD_VERIFY);
    chk({31'h0, er[srv_pkg::BIT_MCR]}, 32'h1);
    $display("media test done");
    stop_test;
  end
  // Runs are well under this span; a hang ends here as a mismatch
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
